// ---- hdl/pcs_map.svh ----
// Register offsets, field positions, reset values and timing figures
// Assumes inclusion by bare name from the power control design files
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define PCS_REG_CFG       8'h10
`define PCS_REG_INTSTAT   8'h11
`define PCS_REG_INTMASK   8'h12
`define PCS_REG_STATUS    8'h13
`define PCS_REG_FAULTMODE 8'he8

// ****************************************
// Fields, reset values and serial device address
// ****************************************
`define PCS_CFG_INTYPE    0
`define PCS_CFG_STBYINV   1
`define PCS_CFG_SEQEN     2
`define PCS_FM_EN         0
`define PCS_INT_FAULT     0
`define PCS_MASK_RST      1'b0
`define PCS_I2C_ADDR      7'h08

// ****************************************
// Timing
// ****************************************
`define PCS_CLK_MHZ       250
`define PCS_RST_DLY_US    2000
`define PCS_FAULT_RST_US  1800
`define PCS_FAULT_OFF_US  100000
`define PCS_HOLD_OFF_MS   4000
`define PCS_WARN_HZ       32768
`define PCS_CNT_W         30

`endif

// ---- hdl/pcs_pkg.sv ----
// Types shared by the power control block and its serial slave
// Assumes the map header is compiled alongside
package pcs_pkg;

	// Effective configuration bits
	typedef struct packed {
		logic seqEnable;
		logic faultMode;
		logic standby_polarity_invert;
		logic inputType;
	} pcs_cfg_s;

	// Register write strobe with address and data
	typedef struct packed {
		logic       en;
		logic [7:0] addr;
		logic [7:0] data;
	} pcs_wr_s;

	typedef enum logic [2:0] {
		PWR_OFF, PWR_START, PWR_DELAY, PWR_ON, PWR_WARN
	} pcs_pwr_e;

	typedef enum logic [3:0] {
		I2C_IDLE, I2C_ADDR, I2C_ACKA, I2C_PTR, I2C_ACKP,
		I2C_WDAT, I2C_ACKW, I2C_RDAT, I2C_RACK
	} pcs_i2c_e;

endpackage : pcs_pkg

// ---- hdl/pcs_i2c_slave.sv ----
// Byte-wide register slave on a two-wire serial bus
// Assumes SCL and SDA arrive synchronous to ref_clk and slow against it
`timescale 1ns/1ns
`default_nettype none
`include "pcs_map.svh"

module pcs_i2c_slave (
	// Clock and reset
	input  wire logic            ref_clk,
	input  wire logic            rst_n,
	// Serial pins
	input  wire logic            sclIn,
	input  wire logic            sdaIn,
	output var  logic            sdaOutEn_n,
	// Register side
	output var pcs_pkg::pcs_wr_s wrBus,
	output var  logic [7:0]      rdAddr,
	input  wire logic [7:0]      rdData
);
	import pcs_pkg::*;

	pcs_i2c_e   st_q;
	logic       sclQ;
	logic       sdaQ;
	logic [7:0] sh_q;
	logic [3:0] cnt_q;
	logic       pull_q;
	logic       nack_q;
	logic       rw_q;
	logic       start;
	logic       stop;
	logic       rise;
	logic       fall;

	assign start = sclIn & sclQ & sdaQ & ~sdaIn;
	assign stop  = sclIn & sclQ & ~sdaQ & sdaIn;
	assign rise  = sclIn & ~sclQ;
	assign fall  = ~sclIn & sclQ;
	assign sdaOutEn_n = ~pull_q;

	// ****************************************
	// Pin history
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclQ <= 1'b1;
			sdaQ <= 1'b1;
		end else begin
			sclQ <= sclIn;
			sdaQ <= sdaIn;
		end
	end

	// ****************************************
	// Protocol engine
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q   <= I2C_IDLE;
			sh_q   <= 8'h00;
			cnt_q  <= 4'h0;
			pull_q <= 1'b0;
			nack_q <= 1'b0;
			rw_q   <= 1'b0;
			rdAddr <= 8'h00;
			wrBus  <= '0;
		end else begin
			wrBus.en <= 1'b0;
			if (start) begin
				st_q   <= I2C_ADDR;
				cnt_q  <= 4'h0;
				pull_q <= 1'b0;
			end else if (stop) begin
				st_q   <= I2C_IDLE;
				pull_q <= 1'b0;
			end else if (rise) begin
				unique case (st_q)
					I2C_ADDR, I2C_PTR, I2C_WDAT: begin
						sh_q  <= {sh_q[6:0], sdaIn};
						cnt_q <= cnt_q + 4'h1;
					end
					I2C_RDAT: cnt_q <= cnt_q + 4'h1;
					I2C_RACK: nack_q <= sdaIn;
					default: ;
				endcase
			end else if (fall) begin
				unique case (st_q)
					I2C_ADDR: if (cnt_q == 4'h8) begin
						rw_q   <= sh_q[0];
						st_q   <= (sh_q[7:1] == `PCS_I2C_ADDR) ? I2C_ACKA : I2C_IDLE;
						pull_q <= (sh_q[7:1] == `PCS_I2C_ADDR);
					end
					I2C_PTR: if (cnt_q == 4'h8) begin
						rdAddr <= sh_q;
						st_q   <= I2C_ACKP;
						pull_q <= 1'b1;
					end
					I2C_WDAT: if (cnt_q == 4'h8) begin
						wrBus  <= '{en: 1'b1, addr: rdAddr, data: sh_q};
						st_q   <= I2C_ACKW;
						pull_q <= 1'b1;
					end
					I2C_ACKA, I2C_ACKP, I2C_ACKW, I2C_RACK: begin
						cnt_q <= 4'h0;
						if (st_q == I2C_ACKW)
							rdAddr <= rdAddr + 8'h01;
						if ((st_q == I2C_ACKA && rw_q) || (st_q == I2C_RACK && !nack_q)) begin
							st_q   <= I2C_RDAT;
							sh_q   <= rdData;
							pull_q <= ~rdData[7];
						end else begin
							st_q   <= (st_q == I2C_ACKA) ? I2C_PTR :
							          (st_q == I2C_RACK) ? I2C_IDLE : I2C_WDAT;
							pull_q <= 1'b0;
						end
					end
					I2C_RDAT: if (cnt_q == 4'h8) begin
						st_q   <= I2C_RACK;
						pull_q <= 1'b0;
						rdAddr <= rdAddr + 8'h01;
					end else begin
						sh_q   <= {sh_q[6:0], 1'b0};
						pull_q <= ~sh_q[6];
					end
					default: ;
				endcase
			end
		end
	end

endmodule : pcs_i2c_slave
`default_nettype wire

// ---- hdl/pcs_power_ctrl.sv ----
// Power control logic facing the processor and the power button
// Assumes pins synchronous to ref_clk; regulators sequenced outside
`timescale 1ns/1ns
`default_nettype none
`include "pcs_map.svh"

module pcs_power_ctrl #(
	parameter int unsigned RST_DLY_CYC   = `PCS_RST_DLY_US * `PCS_CLK_MHZ,
	parameter int unsigned FAULT_RST_CYC = `PCS_FAULT_RST_US * `PCS_CLK_MHZ,
	parameter int unsigned FAULT_OFF_CYC = `PCS_FAULT_OFF_US * `PCS_CLK_MHZ,
	parameter int unsigned HOLD_OFF_CYC  = `PCS_HOLD_OFF_MS * 1000 * `PCS_CLK_MHZ,
	parameter int unsigned WARN_CYC      = (`PCS_CLK_MHZ * 1000000) / `PCS_WARN_HZ
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	// Button and standby inputs
	input  wire logic             powerOnRequest,
	input  wire logic             standbyIn,
	// Processor reset pin
	input  wire logic             processorResetIn,
	output var  logic             processorResetOut,
	output var  logic             processorResetOutEn_n,
	// Shutdown warning pin
	input  wire logic             shutdownWarningIn,
	output var  logic             shutdownWarningOut,
	output var  logic             shutdownWarningOutEn_n,
	// Fault interrupt pin
	input  wire logic             faultIrqIn,
	output var  logic             faultIrqOut,
	output var  logic             faultIrqOutEn_n,
	// Serial register pins
	input  wire logic             sclIn,
	input  wire logic             sdaIn,
	output var  logic             sdaOut,
	output var  logic             sdaOutEn_n,
	// Configuration source
	input  wire logic             prototypeConfigMode,
	input  wire pcs_pkg::pcs_cfg_s otpCfg,
	// Regulator sequencer
	input  wire logic             lastRegulatorOn,
	input  wire logic             powerFault,
	output var  logic             startSequence,
	output var  logic             railsEnable,
	output var  logic             standbyMode
);
	import pcs_pkg::*;

	localparam logic [`PCS_CNT_W-1:0] ONE = `PCS_CNT_W'(1);

	pcs_pwr_e              st_q;
	pcs_cfg_s              cfg_q;
	pcs_cfg_s              effCfg;
	pcs_wr_s               wrBus;
	logic                  loaded_q;
	logic                  intStat_q;
	logic                  intMask_q;
	logic                  faultSeen_q;
	logic                  pwrPrev_q;
	logic                  faultPrev_q;
	logic [`PCS_CNT_W-1:0] faultCnt_q;
	logic [`PCS_CNT_W-1:0] holdCnt_q;
	logic [`PCS_CNT_W-1:0] stCnt_q;
	logic [7:0]            rdAddr;
	logic [7:0]            rdData;
	logic                  onEvent;
	logic                  offEvent;
	logic                  faultLong;
	logic                  faultOff;
	logic                  faultRise;
	logic                  intClr;
	logic                  goOff;

	assign processorResetOut  = 1'b0;
	assign shutdownWarningOut = 1'b0;
	assign faultIrqOut        = 1'b0;
	assign sdaOut             = 1'b0;

	// ****************************************
	// Register interface
	// ****************************************
	pcs_i2c_slave u_i2c (
		.ref_clk    (ref_clk),
		.rst_n      (rst_n),
		.sclIn      (sclIn),
		.sdaIn      (sdaIn),
		.sdaOutEn_n (sdaOutEn_n),
		.wrBus      (wrBus),
		.rdAddr     (rdAddr),
		.rdData     (rdData)
	);

	always_comb begin
		rdData = 8'h00;
		case (rdAddr)
			`PCS_REG_CFG: begin
				rdData[`PCS_CFG_INTYPE]  = cfg_q.inputType;
				rdData[`PCS_CFG_STBYINV] = cfg_q.standby_polarity_invert;
				rdData[`PCS_CFG_SEQEN]   = cfg_q.seqEnable;
			end
			`PCS_REG_FAULTMODE: rdData[`PCS_FM_EN] = cfg_q.faultMode;
			`PCS_REG_INTSTAT:   rdData[`PCS_INT_FAULT] = intStat_q;
			`PCS_REG_INTMASK:   rdData[`PCS_INT_FAULT] = intMask_q;
			`PCS_REG_STATUS:
				rdData = {prototypeConfigMode, faultSeen_q, shutdownWarningIn,
				          faultIrqIn, processorResetIn, standbyMode, railsEnable,
				          powerFault};
			default: rdData = 8'h00;
		endcase
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q    <= '0;
			loaded_q <= 1'b0;
		end else if (!loaded_q) begin
			cfg_q    <= otpCfg;
			loaded_q <= 1'b1;
		end else if (wrBus.en) begin
			if (wrBus.addr == `PCS_REG_CFG) begin
				cfg_q.inputType  <= wrBus.data[`PCS_CFG_INTYPE];
				cfg_q.standby_polarity_invert <= wrBus.data[`PCS_CFG_STBYINV];
				cfg_q.seqEnable  <= wrBus.data[`PCS_CFG_SEQEN];
			end
			if (wrBus.addr == `PCS_REG_FAULTMODE)
				cfg_q.faultMode <= wrBus.data[`PCS_FM_EN];
		end
	end

	assign effCfg = prototypeConfigMode ? cfg_q : otpCfg;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			intMask_q <= `PCS_MASK_RST;
		else if (wrBus.en && wrBus.addr == `PCS_REG_INTMASK)
			intMask_q <= wrBus.data[`PCS_INT_FAULT];
	end

	// ****************************************
	// Fault interrupt
	// ****************************************
	assign faultRise = powerFault & ~faultPrev_q;
	assign intClr    = wrBus.en & (wrBus.addr == `PCS_REG_INTSTAT)
	                 & wrBus.data[`PCS_INT_FAULT];

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			faultPrev_q     <= 1'b0;
			intStat_q       <= 1'b0;
			faultIrqOutEn_n <= 1'b1;
		end else begin
			faultPrev_q     <= powerFault;
			intStat_q       <= faultRise | (intStat_q & ~intClr);
			faultIrqOutEn_n <= ~(intStat_q & ~intMask_q);
		end
	end

	// ****************************************
	// Power-on request decode
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwrPrev_q <= 1'b0;
			holdCnt_q <= '0;
		end else begin
			pwrPrev_q <= powerOnRequest;
			if (powerOnRequest || st_q == PWR_OFF)
				holdCnt_q <= '0;
			else if (holdCnt_q != `PCS_CNT_W'(HOLD_OFF_CYC))
				holdCnt_q <= holdCnt_q + ONE;
		end
	end

	assign onEvent  = effCfg.inputType ? (pwrPrev_q & ~powerOnRequest)
	                                   : powerOnRequest;
	assign offEvent = effCfg.inputType ? (holdCnt_q == `PCS_CNT_W'(HOLD_OFF_CYC - 1))
	                                   : ~powerOnRequest;

	// ****************************************
	// Fault persistence
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			faultCnt_q <= '0;
		else if (!powerFault || st_q == PWR_OFF)
			faultCnt_q <= '0;
		else if (faultCnt_q != `PCS_CNT_W'(FAULT_OFF_CYC))
			faultCnt_q <= faultCnt_q + ONE;
	end

	assign faultLong = faultCnt_q >= `PCS_CNT_W'(FAULT_RST_CYC);
	assign faultOff  = faultCnt_q == `PCS_CNT_W'(FAULT_OFF_CYC);
	assign goOff     = offEvent | (effCfg.faultMode & faultOff);

	// ****************************************
	// Power state machine
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q          <= PWR_OFF;
			stCnt_q       <= '0;
			startSequence <= 1'b0;
			railsEnable   <= 1'b0;
			faultSeen_q   <= 1'b0;
		end else begin
			startSequence <= 1'b0;
			stCnt_q       <= stCnt_q + ONE;
			unique case (st_q)
				PWR_OFF: if (onEvent) begin
					st_q          <= PWR_START;
					startSequence <= 1'b1;
					railsEnable   <= 1'b1;
					faultSeen_q   <= powerFault;
				end
				PWR_START: begin
					faultSeen_q <= faultSeen_q | powerFault;
					stCnt_q     <= '0;
					if (goOff)
						st_q <= PWR_WARN;
					else if (lastRegulatorOn)
						st_q <= (!effCfg.faultMode && effCfg.seqEnable) ? PWR_DELAY : PWR_ON;
				end
				PWR_DELAY: begin
					if (goOff) begin
						st_q    <= PWR_WARN;
						stCnt_q <= '0;
					end else if (stCnt_q == `PCS_CNT_W'(RST_DLY_CYC - 1))
						st_q <= PWR_ON;
				end
				PWR_ON: begin
					stCnt_q <= '0;
					if (goOff)
						st_q <= PWR_WARN;
				end
				PWR_WARN: if (stCnt_q == `PCS_CNT_W'(WARN_CYC - 1)) begin
					st_q        <= PWR_OFF;
					railsEnable <= 1'b0;
				end
				default: st_q <= PWR_OFF;
			endcase
		end
	end

	// ****************************************
	// Pin drivers
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			shutdownWarningOutEn_n <= 1'b1;
		else
			shutdownWarningOutEn_n <= ~((st_q != PWR_WARN && st_q != PWR_OFF && goOff)
			                         || (st_q == PWR_WARN
			                         && stCnt_q != `PCS_CNT_W'(WARN_CYC - 1)));
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			processorResetOutEn_n <= 1'b0;
		else if (st_q == PWR_OFF || st_q == PWR_WARN || goOff)
			processorResetOutEn_n <= 1'b0;
		else if (st_q == PWR_START && lastRegulatorOn && effCfg.faultMode)
			processorResetOutEn_n <= ~(faultSeen_q | powerFault);
		else if (st_q == PWR_START && lastRegulatorOn && !effCfg.seqEnable)
			processorResetOutEn_n <= 1'b1;
		else if (st_q == PWR_DELAY && stCnt_q == `PCS_CNT_W'(RST_DLY_CYC - 1))
			processorResetOutEn_n <= 1'b1;
		else if (st_q == PWR_ON && effCfg.faultMode && faultLong)
			processorResetOutEn_n <= 1'b0;
		else if (st_q == PWR_ON && effCfg.faultMode && !powerFault)
			processorResetOutEn_n <= 1'b1;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			standbyMode <= 1'b0;
		else
			standbyMode <= (st_q == PWR_ON) & (standbyIn ^ effCfg.standby_polarity_invert);
	end

endmodule : pcs_power_ctrl
`default_nettype wire

// ---- verification/pcs_ctrl_props.sv ----
// Concurrent checks on the power control ports
// Assumes the fuse inputs give the mode whenever prototype mode is off
`timescale 1ns/1ns
`default_nettype none

module pcs_ctrl_props #(
	parameter int unsigned RST_DLY_CYC   = 20,
	parameter int unsigned FAULT_RST_CYC = 30,
	parameter int unsigned FAULT_OFF_CYC = 100
) (
	// Clock and reset
	input wire logic              ref_clk,
	input wire logic              rst_n,
	// Observed ports
	input wire logic              powerOnRequest,
	input wire logic              standbyIn,
	input wire logic              processorResetOut,
	input wire logic              processorResetOutEn_n,
	input wire logic              shutdownWarningOut,
	input wire logic              shutdownWarningOutEn_n,
	input wire logic              faultIrqOut,
	input wire logic              faultIrqOutEn_n,
	input wire logic              prototypeConfigMode,
	input wire pcs_pkg::pcs_cfg_s otpCfg,
	input wire logic              lastRegulatorOn,
	input wire logic              powerFault,
	input wire logic              startSequence,
	input wire logic              railsEnable,
	input wire logic              standbyMode
);
	import pcs_pkg::*;

	localparam int RD = RST_DLY_CYC;
	wire logic fuse    = !prototypeConfigMode;
	wire logic fm      = fuse && otpCfg.faultMode;
	wire logic stbyAct = standbyIn ^ otpCfg.standby_polarity_invert;
	logic [31:0] faultRun_q;

	// Consecutive fault cycles while powered
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			faultRun_q <= '0;
		end else begin
			faultRun_q <= (powerFault && railsEnable) ? faultRun_q + 32'h1 : '0;
		end
	end

	default clocking dc @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	// ****
	// Sequences and assertions
	// ****
	sequence warnPulse;
		(!shutdownWarningOutEn_n)[*8] ##1 (shutdownWarningOutEn_n && !railsEnable);
	endsequence
	sequence relWin;
		##RD !processorResetOutEn_n ##[1:2] processorResetOutEn_n;
	endsequence

	start_pulse_a: assert property ($rose(railsEnable) |-> startSequence ##1 !startSequence)
		else $error("start pulse wrong");
	level_on_a: assert property (!railsEnable && powerOnRequest && fuse && !otpCfg.inputType
		&& $past(rst_n) |=> railsEnable) else $error("level turn-on missed");
	edge_on_a: assert property (!railsEnable && $fell(powerOnRequest) && fuse && otpCfg.inputType
		&& $past(rst_n) |=> railsEnable) else $error("edge turn-on missed");
	reset_release_a: assert property (!fm && fuse && otpCfg.seqEnable && railsEnable
		&& $rose(lastRegulatorOn) |-> relWin) else $error("reset release timing wrong");
	off_only_a: assert property (!fm && fuse && $fell(processorResetOutEn_n)
		|-> !shutdownWarningOutEn_n) else $error("reset asserted without turn-off");
	fault_reset_a: assert property (fm && faultRun_q > FAULT_RST_CYC + 2 && shutdownWarningOutEn_n
		|-> !processorResetOutEn_n) else $error("persistent fault left reset high");
	fault_restart_a: assert property (fm && $fell(processorResetOutEn_n) && shutdownWarningOutEn_n
		|-> faultRun_q >= FAULT_RST_CYC) else $error("reset asserted on short fault");
	fault_off_a: assert property (fm && railsEnable && faultRun_q > FAULT_OFF_CYC + 4
		|-> !shutdownWarningOutEn_n) else $error("fault shutdown missed");
	warn_pulse_a: assert property ($fell(shutdownWarningOutEn_n)
		|-> !processorResetOutEn_n ##0 warnPulse) else $error("warning pulse wrong");
	irq_cause_a: assert property ($fell(faultIrqOutEn_n)
		|-> $past(powerFault, 2) || $past(powerFault, 3)) else $error("interrupt without fault");
	stby_level_a: assert property (standbyMode && fuse && !$past(prototypeConfigMode)
		|-> $past(stbyAct)) else $error("standby polarity wrong");
	open_drain_a: assert property (1'b1
		|-> !processorResetOut && !shutdownWarningOut && !faultIrqOut) else $error("pin data not low");
endmodule : pcs_ctrl_props

bind pcs_power_ctrl pcs_ctrl_props #(
	.RST_DLY_CYC(RST_DLY_CYC), .FAULT_RST_CYC(FAULT_RST_CYC), .FAULT_OFF_CYC(FAULT_OFF_CYC)
) pcs_ctrl_props_inst (
	.ref_clk, .rst_n, .powerOnRequest, .standbyIn, .processorResetOut, .processorResetOutEn_n,
	.shutdownWarningOut, .shutdownWarningOutEn_n, .faultIrqOut, .faultIrqOutEn_n,
	.prototypeConfigMode, .otpCfg, .lastRegulatorOn, .powerFault, .startSequence,
	.railsEnable, .standbyMode
);
`default_nettype wire

// ---- verification/pcs_host_model.sv ----
// Processor-side serial master reaching the device registers
// Assumes the bench resolves SDA as open drain with a pull-up
`timescale 1ns/1ns
`default_nettype none
`include "pcs_map.svh"

module pcs_host_model (
	// Clock
	input  wire logic ref_clk,
	// Serial pins
	input  wire logic sdaLine,
	output var  logic sclLine,
	output var  logic sdaPull
);
	localparam logic [6:0] DEV = `PCS_I2C_ADDR;

	initial begin
		sclLine = 1'b1;
		sdaPull = 1'b0;
	end

	task automatic half();
		repeat (4) @(negedge ref_clk);
	endtask : half

	// Eight data bits then the acknowledge bit, MSB first
	task automatic bits(input logic [8:0] o, output logic [8:0] r);
		for (int k = 8; k >= 0; k--) begin
			sdaPull = !o[k];
			half();
			sclLine = 1'b1;
			half();
			r[k] = sdaLine;
			sclLine = 1'b0;
		end
	endtask : bits

	task automatic start();
		sdaPull = 1'b0;
		half();
		sclLine = 1'b1;
		half();
		sdaPull = 1'b1;
		half();
		sclLine = 1'b0;
	endtask : start

	task automatic stop();
		sdaPull = 1'b1;
		half();
		sclLine = 1'b1;
		half();
		sdaPull = 1'b0;
		half();
	endtask : stop

	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
		logic [8:0] r0, r1, r2;
		start();
		bits({DEV, 1'b0, 1'b1}, r0);
		bits({a, 1'b1}, r1);
		bits({d, 1'b1}, r2);
		stop();
		ok = !(r0[0] | r1[0] | r2[0]);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [8:0] r;
		start();
		bits({DEV, 1'b0, 1'b1}, r);
		bits({a, 1'b1}, r);
		start();
		bits({DEV, 1'b1, 1'b1}, r);
		bits(9'h1ff, r);
		stop();
		d = r[8:1];
	endtask : rd
endmodule : pcs_host_model
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the power control block
// Assumes reduced timing parameters and the serial master model
`timescale 1ns/1ns
`default_nettype none

module tb;
	import pcs_pkg::*;

	localparam int RD = 20, FR = 30, FO = 100, HO = 50, WC = 8;
	logic     ref_clk = 1'b0, rst_n = 1'b0, powerOnRequest = 1'b0, standbyIn = 1'b0;
	logic     prototypeConfigMode = 1'b0, lastRegulatorOn = 1'b0, powerFault = 1'b0;
	pcs_cfg_s otpCfg = 4'h8;
	logic     processorResetOut, processorResetOutEn_n, shutdownWarningOut, shutdownWarningOutEn_n;
	logic     faultIrqOut, faultIrqOutEn_n, sdaOut, sdaOutEn_n, sclLine, sdaPull;
	logic     startSequence, railsEnable, standbyMode;
	wire logic       sdaLine = !sdaPull && sdaOutEn_n;
	wire logic [3:0] watch = {railsEnable, processorResetOutEn_n, shutdownWarningOutEn_n, faultIrqOutEn_n};
	int       num_errors = 0, checks_done = 0;

	always #2 ref_clk = !ref_clk;

	pcs_power_ctrl #(
		.RST_DLY_CYC(RD), .FAULT_RST_CYC(FR), .FAULT_OFF_CYC(FO), .HOLD_OFF_CYC(HO), .WARN_CYC(WC)
	) pcs_power_ctrl_inst (
		.ref_clk, .rst_n, .powerOnRequest, .standbyIn,
		.processorResetIn(processorResetOutEn_n), .processorResetOut, .processorResetOutEn_n,
		.shutdownWarningIn(shutdownWarningOutEn_n), .shutdownWarningOut, .shutdownWarningOutEn_n,
		.faultIrqIn(faultIrqOutEn_n), .faultIrqOut, .faultIrqOutEn_n,
		.sclIn(sclLine), .sdaIn(sdaLine), .sdaOut, .sdaOutEn_n, .prototypeConfigMode, .otpCfg,
		.lastRegulatorOn, .powerFault, .startSequence, .railsEnable, .standbyMode
	);
	pcs_host_model pcs_host_model_inst (.ref_clk, .sdaLine, .sclLine, .sdaPull);

	// ****
	// Helpers
	// ****
	task automatic final_report();
		if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : final_report

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk

	task automatic cyc(input int k);
		repeat (k) @(negedge ref_clk);
	endtask : cyc

	task automatic waitOn(input int idx, input logic v, output int n);
		n = 0;
		while (watch[idx] !== v) begin
			cyc(1);
			n++;
			if (n > 400) begin
				num_errors++;
				final_report();
			end
		end
	endtask : waitOn

	task automatic regWr(input logic [7:0] a, input logic [7:0] d);
		logic ok;
		pcs_host_model_inst.wr(a, d, ok);
		chk("ack", 16'h1, 16'(ok));
	endtask : regWr

	task automatic regRd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		pcs_host_model_inst.rd(a, d);
		chk($sformatf("reg %0h", a), 16'(e), 16'(d));
	endtask : regRd

	task automatic powerUp(input logic lvl, input int lo, input int hi);
		int n;
		powerOnRequest = lvl;
		waitOn(3, 1'b1, n);
		chk("startSeq", 16'h1, 16'(startSequence));
		cyc(3);
		lastRegulatorOn = 1'b1;
		waitOn(2, 1'b1, n);
		chk("rstRelease", 16'h1, 16'(n >= lo && n <= hi));
	endtask : powerUp

	task automatic offSeq();
		int n;
		waitOn(1, 1'b0, n);
		chk("rstAtOff", 16'h0, 16'(processorResetOutEn_n));
		waitOn(1, 1'b1, n);
		chk("warnLen", 16'(WC), 16'(n));
		chk("railsOff", 16'h0, 16'(railsEnable));
		lastRegulatorOn = 1'b0;
	endtask : offSeq

	// ****
	// Scenarios
	// ****
	task automatic regsTest();
		regRd(8'h13, 8'h30);
		regRd(8'h12, 8'h00);
		regWr(8'he8, 8'h01);
		regRd(8'he8, 8'h01);
		regWr(8'he8, 8'h00);
		regRd(8'h20, 8'h00);
	endtask : regsTest

	task automatic standbyTest();
		standbyIn = 1'b1;
		cyc(2);
		chk("stby", 16'h1, 16'(standbyMode));
		otpCfg.standby_polarity_invert = 1'b1;
		cyc(2);
		chk("stbyInv", 16'h0, 16'(standbyMode));
		standbyIn = 1'b0;
		cyc(2);
		chk("stbyInvLow", 16'h1, 16'(standbyMode));
		otpCfg.standby_polarity_invert = 1'b0;
		cyc(2);
		chk("stbyExit", 16'h0, 16'(standbyMode));
		regWr(8'h10, 8'h06);
		prototypeConfigMode = 1'b1;
		cyc(2);
		chk("stbyProto", 16'h1, 16'(standbyMode));
		prototypeConfigMode = 1'b0;
	endtask : standbyTest

	task automatic irqTest();
		powerFault = 1'b1;
		cyc(4);
		chk("irq", 16'h0, 16'(faultIrqOutEn_n));
		powerFault = 1'b0;
		regRd(8'h11, 8'h01);
		chk("irqHeld", 16'h0, 16'(faultIrqOutEn_n));
		regWr(8'h11, 8'h01);
		cyc(2);
		chk("irqClr", 16'h1, 16'(faultIrqOutEn_n));
		regWr(8'h12, 8'h01);
		powerFault = 1'b1;
		cyc(4);
		powerFault = 1'b0;
		chk("irqMasked", 16'h1, 16'(faultIrqOutEn_n));
		regWr(8'h11, 8'h01);
		regWr(8'h12, 8'h00);
	endtask : irqTest

	task automatic edgeTest();
		otpCfg.inputType = 1'b1;
		powerOnRequest = 1'b1;
		cyc(3);
		chk("edgeIdle", 16'h0, 16'(railsEnable));
		powerUp(1'b0, RD, RD + 3);
		offSeq();
		otpCfg.inputType = 1'b0;
	endtask : edgeTest

	task automatic faultTest();
		int n;
		otpCfg.faultMode = 1'b1;
		powerUp(1'b1, 0, 3);
		repeat (2) begin
			powerFault = 1'b1;
			cyc(FR - 10);
			powerFault = 1'b0;
			cyc(2);
		end
		chk("rstShortFault", 16'h1, 16'(processorResetOutEn_n));
		powerFault = 1'b1;
		waitOn(2, 1'b0, n);
		chk("rstFault", 16'h1, 16'(n >= FR && n <= FR + 3));
		offSeq();
		waitOn(3, 1'b1, n);
		lastRegulatorOn = 1'b1;
		cyc(3);
		chk("restartRst", 16'h0, 16'(processorResetOutEn_n));
		offSeq();
		powerOnRequest = 1'b0;
		powerFault = 1'b0;
		otpCfg.faultMode = 1'b0;
	endtask : faultTest

	initial begin
		cyc(2);
		rst_n = 1'b1;
		cyc(2);
		regsTest();
		powerUp(1'b1, RD, RD + 3);
		standbyTest();
		irqTest();
		powerOnRequest = 1'b0;
		offSeq();
		edgeTest();
		faultTest();
		final_report();
	end
endmodule : tb
`default_nettype wire
